// ### pkg/power_clock_pkg.sv
// Constants, types and register map of the power and clock control block
package power_clock_pkg;

  localparam int N_EXT  = 9;   // External interrupt pins
  localparam int N_CHAN = 4;   // Interrupt requests to the processor
  localparam int N_PER  = 16;  // Peripheral power switches
  localparam int ADDR_W = 6;
  localparam int STAT_W = 5;   // Four channel flags and one wake flag

  typedef logic [N_EXT-1:0]    ext_t;
  typedef logic [N_CHAN-1:0]   chan_t;
  typedef logic [N_PER-1:0]    periph_t;
  typedef logic [2*N_EXT-1:0]  route_t;
  typedef logic [STAT_W-1:0]   stat_t;
  typedef logic [ADDR_W-1:0]   addr_t;

  // Register byte offsets
  localparam addr_t REG_MODE   = 6'h00;
  localparam addr_t REG_PWR    = 6'h04;
  localparam addr_t REG_DIV    = 6'h08;
  localparam addr_t REG_REMAP  = 6'h0C;
  localparam addr_t REG_EDGE   = 6'h10;
  localparam addr_t REG_POL    = 6'h14;
  localparam addr_t REG_WAKE   = 6'h18;
  localparam addr_t REG_ROUTE  = 6'h1C;
  localparam addr_t REG_STAT   = 6'h20;
  localparam addr_t REG_MASK   = 6'h24;
  localparam addr_t REG_STATE  = 6'h28;

  // Field positions
  localparam int MODE_IDLE_BIT  = 0;
  localparam int MODE_PDOWN_BIT = 1;
  localparam int STAT_WAKE_BIT  = 4;

  // Divider select codes
  localparam logic [1:0] DIV_QUARTER = 2'h0;
  localparam logic [1:0] DIV_FULL    = 2'h1;
  localparam logic [1:0] DIV_HALF    = 2'h2;

  // Values after reset
  localparam logic [1:0] DIV_RESET   = DIV_QUARTER;
  localparam periph_t    PWR_RESET   = 16'hFFFF;
  localparam ext_t       EXT_RESET   = 9'h000;
  localparam route_t     ROUTE_RESET = 18'h00000;

  // Oscillator settle time and the cycles it costs at the 10 ns clock
  localparam int CLK_PERIOD_PS    = 10000;
  localparam int OSC_SETTLE_NS    = 20000;
  localparam int WAKE_W           = 12;
  localparam int WAKE_CYCLES_I    = (OSC_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [WAKE_W-1:0] WAKE_CYCLES = WAKE_W'(WAKE_CYCLES_I);

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_IDLE  = 2'b01,
    ST_PDOWN = 2'b10,
    ST_WAKE  = 2'b11
  } power_e;

endpackage

// ### verilog/ext_pin_detect.sv
// Edge or level detection of the external interrupt pins
`timescale 1ns/1ps
module ext_pin_detect (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire power_clock_pkg::ext_t pin,
  input  wire power_clock_pkg::ext_t edge_mode,
  input  wire power_clock_pkg::ext_t polarity,
  output      power_clock_pkg::ext_t hit
);
  import power_clock_pkg::*;

  typedef struct packed {
    ext_t prev;
  } pin_s;

  pin_s r_ff;
  pin_s nxt_r;

  // Last sample of every pin, for edge detection
  always_comb begin
    nxt_r      = r_ff;
    nxt_r.prev = pin;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // One detector per pin; polarity high means rising edge or high level
  genvar i;
  generate
    for (i = 0; i < N_EXT; i++) begin : g_pin
      assign hit[i] = edge_mode[i] ?
                      (polarity[i] ? (pin[i] & ~r_ff.prev[i]) : (~pin[i] & r_ff.prev[i])) :
                      (pin[i] == polarity[i]);
    end
  endgenerate

endmodule // ext_pin_detect

// ### verilog/power_clock_ctrl.sv
// Power modes, clock gating, peripheral clock divider, remap and external interrupts
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module power_clock_ctrl (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // AXI4-Lite slave
  input  wire power_clock_pkg::addr_t  awaddr,
  input  wire logic                    awvalid,
  output      logic                    awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output      logic                    wready,
  output      logic [1:0]              bresp,
  output      logic                    bvalid,
  input  wire logic                    bready,
  input  wire power_clock_pkg::addr_t  araddr,
  input  wire logic                    arvalid,
  output      logic                    arready,
  output      logic [31:0]             rdata,
  output      logic [1:0]              rresp,
  output      logic                    rvalid,
  input  wire logic                    rready,
  // System side
  input  wire power_clock_pkg::ext_t   ext_int_pin,
  input  wire logic                    cpu_irq_pending,
  input  wire logic                    pll_running,
  output      power_clock_pkg::chan_t  ext_irq_req,
  output      logic                    irq,
  output      logic                    cpu_clock_en,
  output      logic                    mem_clk_en,
  output      logic                    bus_clk_en,
  output      logic                    osc_en,
  output      logic                    pll_keep,
  output      logic                    pin_hold,
  output      logic                    pclk_en,
  output      power_clock_pkg::periph_t periph_pwr_en,
  output      logic                    vec_sram
);
  import power_clock_pkg::*;

  typedef struct packed {
    power_e            pstate;
    logic [WAKE_W-1:0] wake_cnt;
    logic              mode_idle;
    logic              mode_pdown;
    periph_t           pwr_en;
    logic [1:0]        div_sel;
    logic [1:0]        div_cnt;
    logic              pclk_en;
    logic              vec_sram;
    ext_t              ext_edge;
    ext_t              ext_pol;
    ext_t              ext_wake;
    route_t            route;
    stat_t             status;
    stat_t             mask;
    chan_t             irq_req;
    logic              irq;
    logic              cpu_clk_en;
    logic              mem_clk_en;
    logic              bus_clk_en;
    logic              osc_en;
    logic              pll_keep;
    logic              pin_hold;
    logic              aw_got;
    logic              w_got;
    addr_t             waddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } state_s;

  state_s r_ff;
  state_s nxt_r;
  ext_t   pin_hit;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction

  ext_pin_detect u_detect (
    .clk       (clk),
    .resetn    (resetn),
    .pin       (ext_int_pin),
    .edge_mode (r_ff.ext_edge),
    .polarity  (r_ff.ext_pol),
    .hit       (pin_hit)
  );

  always_comb begin
    logic [31:0] old;
    logic [31:0] wv;
    logic        do_wr;
    logic        wake_pin;
    logic        wake_any;
    stat_t       set;
    stat_t       clr;
    old      = '0;
    wv       = '0;
    do_wr    = 1'b0;
    set      = '0;
    clr      = '0;
    wake_pin = 1'b0;
    wake_any = 1'b0;
    nxt_r    = r_ff;

    // Route each pin onto its chosen request line
    for (int i = 0; i < N_EXT; i++) begin
      for (int c = 0; c < N_CHAN; c++) begin
        if (pin_hit[i] && (r_ff.route[2*i +: 2] == 2'(c))) begin
          set[c] = 1'b1;
        end
      end
    end

    // Only pins enabled for wake-up may end power-down
    wake_pin = |(pin_hit & r_ff.ext_wake);

    // AXI write: address and data taken in either order
    if (awvalid && r_ff.awready) begin
      nxt_r.aw_got = 1'b1;
      nxt_r.waddr  = awaddr;
    end
    if (wvalid && r_ff.wready) begin
      nxt_r.w_got = 1'b1;
      nxt_r.wdata = wdata;
      nxt_r.wstrb = wstrb;
    end
    if (r_ff.bvalid && bready) begin
      nxt_r.bvalid = 1'b0;
    end
    do_wr = r_ff.aw_got && r_ff.w_got && !r_ff.bvalid;
    if (do_wr) begin
      nxt_r.aw_got = 1'b0;
      nxt_r.w_got  = 1'b0;
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp  = RESP_OKAY;
      case (r_ff.waddr)
        REG_MODE: begin
          wv = merge(32'h0000_0000, r_ff.wdata, r_ff.wstrb);
          // Mode requests only take effect while running
          if (r_ff.pstate == ST_RUN) begin
            nxt_r.mode_pdown = wv[MODE_PDOWN_BIT];
            nxt_r.mode_idle  = wv[MODE_IDLE_BIT] & ~wv[MODE_PDOWN_BIT];
          end
        end
        REG_PWR: begin
          old          = 32'(r_ff.pwr_en);
          wv           = merge(old, r_ff.wdata, r_ff.wstrb);
          nxt_r.pwr_en = wv[N_PER-1:0];
        end
        REG_DIV: begin
          old           = {30'h0000_0000, r_ff.div_sel};
          wv            = merge(old, r_ff.wdata, r_ff.wstrb);
          nxt_r.div_sel = wv[1:0];
        end
        REG_REMAP: begin
          old            = {31'h0000_0000, r_ff.vec_sram};
          wv             = merge(old, r_ff.wdata, r_ff.wstrb);
          nxt_r.vec_sram = wv[0];
        end
        REG_EDGE: begin
          old            = 32'(r_ff.ext_edge);
          wv             = merge(old, r_ff.wdata, r_ff.wstrb);
          nxt_r.ext_edge = wv[N_EXT-1:0];
        end
        REG_POL: begin
          old           = 32'(r_ff.ext_pol);
          wv            = merge(old, r_ff.wdata, r_ff.wstrb);
          nxt_r.ext_pol = wv[N_EXT-1:0];
        end
        REG_WAKE: begin
          old            = 32'(r_ff.ext_wake);
          wv             = merge(old, r_ff.wdata, r_ff.wstrb);
          nxt_r.ext_wake = wv[N_EXT-1:0];
        end
        REG_ROUTE: begin
          old         = 32'(r_ff.route);
          wv          = merge(old, r_ff.wdata, r_ff.wstrb);
          nxt_r.route = wv[2*N_EXT-1:0];
        end
        REG_STAT: begin
          wv  = merge(32'h0000_0000, r_ff.wdata, r_ff.wstrb);
          clr = wv[STAT_W-1:0];
        end
        REG_MASK: begin
          old        = 32'(r_ff.mask);
          wv         = merge(old, r_ff.wdata, r_ff.wstrb);
          nxt_r.mask = wv[STAT_W-1:0];
        end
        REG_STATE: nxt_r.bresp = RESP_OKAY; // Read-only, writes ignored
        default:   nxt_r.bresp = RESP_SLVERR;
      endcase
    end

    // AXI read: answer one cycle after the address is taken
    if (r_ff.rvalid && rready) begin
      nxt_r.rvalid = 1'b0;
    end
    if (arvalid && r_ff.arready) begin
      nxt_r.rvalid = 1'b1;
      nxt_r.rresp  = RESP_OKAY;
      case (araddr)
        REG_MODE:  nxt_r.rdata = {30'h0000_0000, r_ff.mode_pdown, r_ff.mode_idle};
        REG_PWR:   nxt_r.rdata = 32'(r_ff.pwr_en);
        REG_DIV:   nxt_r.rdata = {30'h0000_0000, r_ff.div_sel};
        REG_REMAP: nxt_r.rdata = {31'h0000_0000, r_ff.vec_sram};
        REG_EDGE:  nxt_r.rdata = 32'(r_ff.ext_edge);
        REG_POL:   nxt_r.rdata = 32'(r_ff.ext_pol);
        REG_WAKE:  nxt_r.rdata = 32'(r_ff.ext_wake);
        REG_ROUTE: nxt_r.rdata = 32'(r_ff.route);
        REG_STAT:  nxt_r.rdata = 32'(r_ff.status);
        REG_MASK:  nxt_r.rdata = 32'(r_ff.mask);
        REG_STATE: nxt_r.rdata = {28'h000_0000, r_ff.div_sel, r_ff.pstate};
        default: begin
          nxt_r.rdata = 32'h0000_0000;
          nxt_r.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Power state machine
    wake_any = (|r_ff.irq_req) | cpu_irq_pending | r_ff.irq;
    case (r_ff.pstate)
      ST_RUN: begin
        if (r_ff.mode_pdown) begin
          nxt_r.pstate = ST_PDOWN;
        end else if (r_ff.mode_idle) begin
          nxt_r.pstate = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // Any pending interrupt resumes execution
        if (wake_any) begin
          nxt_r.pstate    = ST_RUN;
          nxt_r.mode_idle = 1'b0;
        end
      end
      ST_PDOWN: begin
        // Clocked interrupt sources cannot run here, so only wake pins count
        if (wake_pin) begin
          nxt_r.pstate     = ST_WAKE;
          nxt_r.mode_pdown = 1'b0;
          nxt_r.wake_cnt   = WAKE_CYCLES;
          set[STAT_WAKE_BIT] = 1'b1;
        end
      end
      ST_WAKE: begin
        // Hold execution off until the restarted oscillator has settled
        if (r_ff.wake_cnt <= WAKE_W'(1)) begin
          nxt_r.pstate   = ST_RUN;
          nxt_r.wake_cnt = '0;
        end else begin
          nxt_r.wake_cnt = r_ff.wake_cnt - WAKE_W'(1);
        end
      end
      default: nxt_r.pstate = ST_RUN;
    endcase

    // Sticky status; a new event wins over a clear in the same cycle
    nxt_r.status  = (r_ff.status & ~clr) | set;
    nxt_r.irq_req = nxt_r.status[N_CHAN-1:0];
    nxt_r.irq     = |(nxt_r.status & nxt_r.mask);

    // Peripheral clock divider; idle leaves it running so peripherals can still interrupt
    nxt_r.div_cnt = r_ff.div_cnt + 2'h1;
    case (r_ff.div_sel)
      DIV_FULL: nxt_r.pclk_en = 1'b1;
      DIV_HALF: nxt_r.pclk_en = r_ff.div_cnt[0];
      default:  nxt_r.pclk_en = (r_ff.div_cnt == 2'h3);
    endcase
    if (nxt_r.pstate == ST_PDOWN || nxt_r.pstate == ST_WAKE) begin
      nxt_r.pclk_en = 1'b0;
    end

    // Clock gates follow the next power state
    nxt_r.cpu_clk_en = (nxt_r.pstate == ST_RUN);
    nxt_r.mem_clk_en = (nxt_r.pstate == ST_RUN);
    nxt_r.bus_clk_en = (nxt_r.pstate == ST_RUN);
    nxt_r.osc_en     = (nxt_r.pstate != ST_PDOWN);
    nxt_r.pll_keep   = pll_running && (nxt_r.pstate != ST_PDOWN);
    // Freezing the pins keeps outputs static while nothing is clocked
    nxt_r.pin_hold   = (nxt_r.pstate == ST_PDOWN) || (nxt_r.pstate == ST_WAKE);

    // Ready flags from next state, so each channel takes one item at a time
    nxt_r.awready = !nxt_r.aw_got && !nxt_r.bvalid;
    nxt_r.wready  = !nxt_r.w_got && !nxt_r.bvalid;
    nxt_r.arready = !nxt_r.rvalid;
  end

  // Single state register; all values retained through power-down
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_ff            <= '0;
      r_ff.pstate     <= ST_RUN;
      r_ff.pwr_en     <= PWR_RESET;
      r_ff.div_sel    <= DIV_RESET;
      r_ff.ext_edge   <= EXT_RESET;
      r_ff.ext_pol    <= EXT_RESET;
      r_ff.ext_wake   <= EXT_RESET;
      r_ff.route      <= ROUTE_RESET;
      r_ff.cpu_clk_en <= 1'b1;
      r_ff.mem_clk_en <= 1'b1;
      r_ff.bus_clk_en <= 1'b1;
      r_ff.osc_en     <= 1'b1;
      r_ff.awready    <= 1'b1;
      r_ff.wready     <= 1'b1;
      r_ff.arready    <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Every output comes straight from the state register
  assign awready       = r_ff.awready;
  assign wready        = r_ff.wready;
  assign bvalid        = r_ff.bvalid;
  assign bresp         = r_ff.bresp;
  assign arready       = r_ff.arready;
  assign rvalid        = r_ff.rvalid;
  assign rresp         = r_ff.rresp;
  assign rdata         = r_ff.rdata;
  assign ext_irq_req   = r_ff.irq_req;
  assign irq           = r_ff.irq;
  assign cpu_clock_en  = r_ff.cpu_clk_en;
  assign mem_clk_en    = r_ff.mem_clk_en;
  assign bus_clk_en    = r_ff.bus_clk_en;
  assign osc_en        = r_ff.osc_en;
  assign pll_keep      = r_ff.pll_keep;
  assign pin_hold      = r_ff.pin_hold;
  assign pclk_en       = r_ff.pclk_en;
  assign periph_pwr_en = r_ff.pwr_en;
  assign vec_sram      = r_ff.vec_sram;

endmodule // power_clock_ctrl

// ### tb/power_clock_checker.sv
// Concurrent checks of the power and clock control block
`timescale 1ns/1ps
module power_clock_checker
  import power_clock_pkg::*;
(
  input wire logic                     clk,
  input wire logic                     resetn,
  input wire logic                     bvalid,
  input wire logic                     cpu_irq_pending,
  input wire logic                     pll_running,
  input wire logic                     cpu_clock_en,
  input wire logic                     mem_clk_en,
  input wire logic                     bus_clk_en,
  input wire logic                     osc_en,
  input wire logic                     pll_keep,
  input wire logic                     pin_hold,
  input wire logic                     pclk_en,
  input wire power_clock_pkg::periph_t periph_pwr_en,
  input wire logic                     vec_sram
);
  logic [11:0] wcnt_ff;

  // Wake-up cycles with the oscillator back on; resets whenever pins are free
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) wcnt_ff <= 12'h000;
    else if (!pin_hold) wcnt_ff <= 12'h000;
    else if (osc_en) wcnt_ff <= wcnt_ff + 12'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_idle_gates: assert property (
    mem_clk_en == cpu_clock_en && bus_clk_en == cpu_clock_en)
    else $error("memory or bus clock enable differs from core clock enable");
  a_pdown_off: assert property (!osc_en |-> pin_hold && !cpu_clock_en && !pclk_en)
    else $error("clock still delivered with oscillator off");
  a_pdown_frozen: assert property (
    !osc_en && $past(!osc_en) |-> $stable(periph_pwr_en) && $stable(vec_sram))
    else $error("outputs moved during power-down");
  a_pll_kept: assert property (
    $past(resetn) && $past(osc_en) && osc_en |-> pll_keep == $past(pll_running))
    else $error("pll keep does not follow pll state");
  a_pclk_gated: assert property (pclk_en |-> osc_en && !pin_hold)
    else $error("peripheral clock pulse while oscillator stopped or waking");
  a_idle_wake: assert property (
    cpu_irq_pending && !cpu_clock_en && osc_en && !pin_hold |=> cpu_clock_en)
    else $error("idle not left on pending interrupt");
  a_wake_timer: assert property ($fell(pin_hold) |->
    wcnt_ff >= WAKE_CYCLES - 12'h001 && wcnt_ff <= WAKE_CYCLES + 12'h001)
    else $error("wake-up timer length wrong");
  a_wake_start: assert property ($rose(osc_en) |-> pin_hold && !cpu_clock_en)
    else $error("core clock back before wake-up timer");
  a_remap_write: assert property ($changed(vec_sram) |-> $rose(bvalid))
    else $error("vector map changed without a write");
  a_pwr_write: assert property ($changed(periph_pwr_en) |-> $rose(bvalid))
    else $error("power enables changed without a write");

  cov_idle_exit: cover property ($rose(cpu_clock_en) && !$past(pin_hold));
  cov_pdown_exit: cover property ($fell(pin_hold));
  cov_remap: cover property ($rose(vec_sram));
endmodule // power_clock_checker

bind power_clock_ctrl power_clock_checker u_chk (.clk(clk), .resetn(resetn), .bvalid(bvalid),
  .cpu_irq_pending(cpu_irq_pending), .pll_running(pll_running), .cpu_clock_en(cpu_clock_en),
  .mem_clk_en(mem_clk_en), .bus_clk_en(bus_clk_en), .osc_en(osc_en), .pll_keep(pll_keep),
  .pin_hold(pin_hold), .pclk_en(pclk_en), .periph_pwr_en(periph_pwr_en), .vec_sram(vec_sram));

// ### tb/cpu_model.sv
// Processor-side model: wakes itself by interrupt and reports its PLL
`timescale 1ns/1ps
module cpu_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       cpu_clock_en,
  input  wire logic       pll_on,
  input  wire logic [7:0] wake_delay,
  output      logic       cpu_irq_pending,
  output      logic       pll_running
);
  logic [7:0] stall_ff;

  // A peripheral timer fires a while after the core stops; zero delay never fires
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stall_ff        <= 8'h00;
      cpu_irq_pending <= 1'b0;
      pll_running     <= 1'b0;
    end else begin
      stall_ff        <= cpu_clock_en ? 8'h00 : stall_ff + 8'h01;
      cpu_irq_pending <= !cpu_clock_en && wake_delay != 8'h00 && stall_ff >= wake_delay;
      pll_running     <= pll_on;
    end
  end
endmodule // cpu_model

// ### tb/tb_top.sv
// Self-checking bench of the power and clock control block
`timescale 1ns/1ps
module tb_top;
  import power_clock_pkg::*;
  logic        clk = 1'b0, resetn = 1'b0, pll_on = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  addr_t       awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rnd = 32'h1F66, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic [7:0]  wake_delay = 8'h28;
  ext_t        pins = '1;
  logic        awready, wready, bvalid, arready, rvalid, irq, cpu_irq_pending, pll_running;
  logic        cpu_clock_en, mem_clk_en, bus_clk_en, osc_en, pll_keep, pin_hold, pclk_en;
  logic        vec_sram;
  logic [1:0]  bresp, rresp, resp;
  chan_t       ext_irq_req;
  periph_t     periph_pwr_en;
  logic [1:0]  div_seq [4] = '{DIV_FULL, DIV_HALF, 2'h3, DIV_QUARTER};
  int          miscompares = 0, n_tests = 0, n;

  power_clock_ctrl dut (.clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ext_int_pin(pins), .cpu_irq_pending(cpu_irq_pending), .pll_running(pll_running),
    .ext_irq_req(ext_irq_req), .irq(irq), .cpu_clock_en(cpu_clock_en), .mem_clk_en(mem_clk_en),
    .bus_clk_en(bus_clk_en), .osc_en(osc_en), .pll_keep(pll_keep), .pin_hold(pin_hold),
    .pclk_en(pclk_en), .periph_pwr_en(periph_pwr_en), .vec_sram(vec_sram));
  cpu_model u_cpu (.clk(clk), .resetn(resetn), .cpu_clock_en(cpu_clock_en), .pll_on(pll_on),
    .wake_delay(wake_delay), .cpu_irq_pending(cpu_irq_pending), .pll_running(pll_running));

  // 100 MHz clock
  initial forever #5 clk = ~clk;

  // Stimulus source and expectations
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int gap_of(input logic [1:0] s);
    return (s == DIV_FULL) ? 1 : (s == DIV_HALF) ? 2 : 4;
  endfunction
  function automatic chan_t chan_hit(input route_t r, input int i);
    return chan_t'(1) << r[2*i +: 2];
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Write one word; ready is sampled at the falling edge, acted on at the next rising edge
  task automatic wr(input addr_t a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      {aw, w, b, resp} = {awready, wready, bvalid, bresp};
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(32'(resp), 32'(er));
  endtask

  // Read one word and compare its masked value and the response
  task automatic rd(input addr_t a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    logic ar, r;
    logic [31:0] d;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      {ar, r, d, resp} = {arready, rvalid, rdata, rresp};
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(d & m, e);
    chk(32'(resp), 32'(er));
  endtask

  // Third interval between peripheral pulses, so a divider change has settled
  task automatic pclk_gap(input int e);
    int g;
    repeat (3) begin
      g = 0;
      do begin
        @(negedge clk);
        g++;
      end while (pclk_en !== 1'b1 && g < 9);
    end
    chk(32'(g), 32'(e));
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(REG_DIV, 32'h3, 32'(DIV_RESET), RESP_OKAY);
    pclk_gap(4);
    rd(REG_PWR, 32'hFFFF, 32'(PWR_RESET), RESP_OKAY);
    rd(6'h3C, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    wr(6'h3C, 32'h1, RESP_SLVERR);
    chk(32'(vec_sram), 32'h0);
    foreach (div_seq[k]) begin
      wr(REG_DIV, 32'(div_seq[k]), RESP_OKAY);
      pclk_gap(gap_of(div_seq[k]));
      rd(REG_STATE, 32'hF, 32'({div_seq[k], 2'(ST_RUN)}), RESP_OKAY);
    end
    rnd = lfsr(rnd);
    wr(REG_PWR, 32'(rnd[15:0]), RESP_OKAY);
    chk(32'(periph_pwr_en), 32'(rnd[15:0]));
    for (int v = 1; v >= 0; v--) begin
      wr(REG_REMAP, 32'(v), RESP_OKAY);
      chk(32'(vec_sram), 32'(v));
    end
    // Low level on each pin, routed at random, all channels unmasked
    wr(REG_MASK, 32'h1F, RESP_OKAY);
    for (int i = 0; i < N_EXT; i++) begin
      rnd = lfsr(rnd);
      wr(REG_ROUTE, 32'(rnd[17:0]), RESP_OKAY);
      wr(REG_STAT, 32'h1F, RESP_OKAY);
      pins[i] <= 1'b0;
      pll_on  <= rnd[18];
      repeat (3) @(posedge clk);
      pins <= '1;
      @(negedge clk);
      chk(32'(ext_irq_req), 32'(chan_hit(rnd[17:0], i)));
      chk(32'(pll_keep), 32'(rnd[18]));
      chk(32'(irq), 32'h1);
    end
    // Rising edge, masked: flag sets once and stays clear while the pin stays high
    wr(REG_EDGE, 32'h1FF, RESP_OKAY);
    pll_on <= 1'b1;
    wr(REG_POL, 32'h1FF, RESP_OKAY);
    pins <= '0;
    wr(REG_MASK, 32'h0, RESP_OKAY);
    wr(REG_STAT, 32'h1F, RESP_OKAY);
    pins[3] <= 1'b1;
    repeat (3) @(negedge clk);
    chk(32'({irq, |ext_irq_req}), 32'h1);
    wr(REG_STAT, 32'h1F, RESP_OKAY);
    rd(REG_STAT, 32'hF, 32'h0, RESP_OKAY);
    pins <= '0;
    // Idle: peripherals keep clocking until the model's timer wakes the core
    wr(REG_MODE, 32'h1, RESP_OKAY);
    for (n = 0; n < 50 && cpu_clock_en !== 1'b0; n++) @(negedge clk);
    chk(32'({mem_clk_en, bus_clk_en, osc_en, pll_keep}), 32'h3);
    pclk_gap(4);
    for (n = 0; n < 80 && cpu_clock_en !== 1'b1; n++) @(negedge clk);
    chk(32'(cpu_clock_en), 32'h1);
    rd(REG_MODE, 32'h3, 32'h0, RESP_OKAY);
    // Power-down: only the wake-enabled pin ends it, through the wake-up timer
    wr(REG_WAKE, 32'h1, RESP_OKAY);
    wr(REG_MODE, 32'h3, RESP_OKAY);
    for (n = 0; n < 50 && osc_en !== 1'b0; n++) @(negedge clk);
    chk(32'({pin_hold, cpu_clock_en, pclk_en}), 32'h4);
    rnd = lfsr(rnd);
    repeat (60 + int'(rnd[4:0])) @(posedge clk);
    pins <= 9'h002;
    repeat (5) @(negedge clk);
    chk(32'(osc_en), 32'h0);
    @(posedge clk);
    pins <= 9'h003;
    for (n = 0; n < 10 && osc_en !== 1'b1; n++) @(negedge clk);
    chk(32'({pin_hold, cpu_clock_en}), 32'h2);
    for (n = 0; n < 3000 && cpu_clock_en !== 1'b1; n++) @(negedge clk);
    chk(32'(n >= int'(WAKE_CYCLES) - 3 && n <= int'(WAKE_CYCLES) + 1), 32'h1);
    rd(REG_STAT, 32'h10, 32'h10, RESP_OKAY);
    rd(REG_MODE, 32'h3, 32'h0, RESP_OKAY);
    conclude();
  end

  // Cut a hang short; the whole run needs well under 10000 cycles
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule // tb_top
